// [design/rts_defines.svh]
`ifndef RTS_DEFINES_SVH
`define RTS_DEFINES_SVH
// ====================================================================
// Register byte offsets.
`define RTS_OFF_ACC1     12'h000
`define RTS_OFF_DEC1     12'h004
`define RTS_OFF_ACC2     12'h008
`define RTS_OFF_DEC2     12'h00C
`define RTS_OFF_ACC3     12'h010
`define RTS_OFF_DEC3     12'h014
`define RTS_OFF_ACC4     12'h018
`define RTS_OFF_DEC4     12'h01C
`define RTS_OFF_FSTOP    12'h020
`define RTS_OFF_UNIT     12'h024
`define RTS_OFF_SWFREQ   12'h028
`define RTS_OFF_DIFUNC   12'h02C
`define RTS_OFF_MAXFREQ  12'h030
`define RTS_OFF_STATUS   12'h034
`define RTS_OFF_IRQ_STAT 12'h038
`define RTS_OFF_IRQ_MASK 12'h03C
`define RTS_OFF_ACTIVE   12'h040
// ====================================================================
// Reset values (times in 0.1 s steps, frequency in 0.1 Hz steps).
`define RTS_RST_TIME     16'h0064
`define RTS_RST_UNIT     1'b1
`define RTS_RST_SWFREQ   16'h0000
`define RTS_RST_MAXFREQ  16'h0258
`define RTS_RST_DIFUNC   32'h0000_0000
// Fine unit limit: 600.1 s in coarse steps is 6001 counts.
`define RTS_FINE_LIMIT   16'h1771
// ====================================================================
// Digital input function codes.
`define RTS_FN_SEL1      8'h07
`define RTS_FN_SEL2      8'h1A
`define RTS_FN_FSTOP_NO  8'h15
`define RTS_FN_FSTOP_NC  8'h17
`define RTS_FN_MOTOR2    8'h16
// ====================================================================
// Interrupt bit positions and the number of terminal inputs.
`define RTS_IRQ_FSTOP    0
`define RTS_IRQ_CONFLICT 1
`define RTS_IRQ_UNITREJ  2
`define RTS_IRQ_DONE     3
`define RTS_NUM_INPUTS   4
`endif

// [design/rts_pkg.sv]
package rts_pkg;
  // Fast-stop latch states.
  typedef enum logic [1:0] {
    RTS_FS_IDLE,
    RTS_FS_DECEL,
    RTS_FS_WAIT
  } rts_fs_type;

  // Register state of the selector top, apart from the run edge flop run_d_r.
  typedef struct packed {
    logic [8:0][15:0] time_set;
    logic             unit_fine;
    logic [15:0]      sw_freq;
    logic [15:0]      max_freq;
    logic [31:0]      di_func;
    logic [3:0]       irq_stat;
    logic [3:0]       irq_mask;
    logic             conflict;
    rts_fs_type       fs_state;
    logic             run_ok;
    logic             irq;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic [15:0]      acc_time;
    logic [15:0]      dec_time;
    logic [1:0]       pair;
    logic             fstop_act;
  } rts_state_type;
endpackage

// [design/rts_selector.sv]
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/100ps
`include "rts_defines.svh"
// Summary of operation
// RULE1: Inputs seven and 1A pick pair one to four by their closed states.
// RULE2: Function 15 input closing starts fast stop with the fast stop time.
// RULE3: Function 17 input opening starts fast stop.
// RULE4: Fast stop latches; run needs done, input clear and run re-applied.
// RULE5: Unit setting scales all nine times: 0.01 s fine, 0.1 s coarse.
// RULE6: Fine unit is refused while any time holds 600.1 s or more.
// RULE7: Auto switch with inputs open: pair 1 at or above, pair 4 below.
// RULE8: A zero switch frequency disables automatic switching.
// RULE9: Times span zero to maximum frequency; slope is fmax over time.
// RULE10: Motor 2 uses pair 3 above, 4 below; closed input gives pair 4.
// RULE11: Second select plus motor switch function raises a config error.
// RULE12: Fast stop time is its own setting, same unit, default 10.0 s.
// RULE13: Selection is re-evaluated each cycle; the pair register presents it one clock later.
module rts_selector
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  di_pin,
  input  wire logic        run_cmd,
  input  wire logic        motor2_sel,
  input  wire logic [15:0] out_freq,
  input  wire logic        decel_done,
  output logic      [15:0] acc_time,
  output logic      [15:0] dec_time,
  output logic      [1:0]  ramp_pair,
  output logic             unit_fine,
  output logic             fast_stop,
  output logic             run_enable,
  output logic             input_conflict_error,
  output logic             irq
);
  rts_pkg::rts_state_type st_r;
  rts_pkg::rts_state_type st_nxt;
  logic [4:0]             sync_q;
  logic [3:0]             di_s;
  logic                   run_s;
  logic                   run_d_r;

  // Terminal inputs and run command pass two flip-flops first.
  rts_sync u_sync
  (
    .pclk    (pclk),
    .presetn (presetn),
    .d_in    ({run_cmd, di_pin}),
    .q_out   (sync_q)
  );
  assign di_s  = sync_q[3:0];
  assign run_s = sync_q[4];

  // Returns whether any terminal carries the given function code.
  function automatic logic has_fn(input logic [31:0] f,
                                  input logic [3:0]  d,
                                  input logic [7:0]  code,
                                  input logic        want_closed);
    logic r;
    r = 1'b0;
    for (int i = 0; i < `RTS_NUM_INPUTS; i++)
    begin
      if (f[i*8 +: 8] == code && (!want_closed || d[i]))
        r = 1'b1;
    end
    return r;
  endfunction

  // Tells whether a function code is assigned to any terminal.
  function automatic logic fn_used(input logic [31:0] f,
                                   input logic [7:0]  code);
    return has_fn(f, 4'hF, code, 1'b0);
  endfunction

  // Tracks run command edges for the restart condition.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      run_d_r <= 1'b0;
    else
      run_d_r <= run_s;
  end

  // Next state: bus access, interrupts, fast stop and pair selection.
  always_comb
  begin
    logic       wr;
    logic       rd;
    logic [3:0] ev;
    logic       sel1;
    logic       sel2;
    logic       above;
    logic       auto_on;
    logic       fs_trig;
    logic       big;
    logic       conf;
    logic [1:0] p;
    wr      = 1'b0;
    rd      = 1'b0;
    ev      = 4'h0;
    sel1    = 1'b0;
    sel2    = 1'b0;
    above   = 1'b0;
    auto_on = 1'b0;
    fs_trig = 1'b0;
    big     = 1'b0;
    conf    = 1'b0;
    p       = 2'h0;
    st_nxt  = st_r;
    wr = psel && penable && pwrite;
    rd = psel && penable && !pwrite;
    st_nxt.pready  = psel && penable && !st_r.pready;
    st_nxt.pslverr = 1'b0;
    for (int i = 0; i < 9; i++)
      if (st_r.time_set[i] >= `RTS_FINE_LIMIT)
        big = 1'b1; // RULE6
    // Register writes take effect in the access phase's answer cycle.
    if (wr && !st_r.pready)
    begin
      if (paddr <= `RTS_OFF_FSTOP && paddr[1:0] == 2'h0)
        st_nxt.time_set[paddr[5:2]] = pwdata[15:0]; // RULE12
      else
        case (paddr)
          `RTS_OFF_UNIT:
          begin
            if (!pwdata[0] && big)
            begin
              st_nxt.pslverr = 1'b1; // RULE6
              ev[`RTS_IRQ_UNITREJ] = 1'b1;
            end
            else
              st_nxt.unit_fine = !pwdata[0]; // RULE5
          end
          `RTS_OFF_SWFREQ:   st_nxt.sw_freq  = pwdata[15:0];
          `RTS_OFF_MAXFREQ:  st_nxt.max_freq = pwdata[15:0];
          `RTS_OFF_DIFUNC:
          begin
            conf = fn_used(pwdata, `RTS_FN_SEL2)
                && fn_used(pwdata, `RTS_FN_MOTOR2);
            st_nxt.conflict = conf; // RULE11
            if (conf)
            begin
              st_nxt.pslverr = 1'b1;
              ev[`RTS_IRQ_CONFLICT] = 1'b1;
            end
            else
              st_nxt.di_func = pwdata;
          end
          `RTS_OFF_IRQ_MASK: st_nxt.irq_mask = pwdata[3:0];
          default:           st_nxt.pslverr = !(paddr <= `RTS_OFF_ACTIVE);
        endcase
    end
    // Read data; the read of interrupt status clears that register below.
    st_nxt.prdata = 32'h0000_0000;
    if (rd && !st_r.pready)
    begin
      if (paddr <= `RTS_OFF_FSTOP && paddr[1:0] == 2'h0)
        st_nxt.prdata = {16'h0000, st_r.time_set[paddr[5:2]]};
      else
        case (paddr)
          `RTS_OFF_UNIT:     st_nxt.prdata = {31'h0, !st_r.unit_fine};
          `RTS_OFF_SWFREQ:   st_nxt.prdata = {16'h0, st_r.sw_freq};
          `RTS_OFF_MAXFREQ:  st_nxt.prdata = {16'h0, st_r.max_freq};
          `RTS_OFF_DIFUNC:   st_nxt.prdata = st_r.di_func;
          `RTS_OFF_STATUS:
            st_nxt.prdata = {26'h0, st_r.conflict, st_r.run_ok,
                             st_r.fstop_act, st_r.unit_fine, st_r.pair};
          `RTS_OFF_IRQ_STAT: st_nxt.prdata = {28'h0, st_r.irq_stat};
          `RTS_OFF_IRQ_MASK: st_nxt.prdata = {28'h0, st_r.irq_mask};
          `RTS_OFF_ACTIVE:
            st_nxt.prdata = {st_r.dec_time, st_r.acc_time};
          default:           st_nxt.pslverr = 1'b1;
        endcase
    end
    // Selection inputs sampled from terminals.
    sel1 = has_fn(st_r.di_func, di_s, `RTS_FN_SEL1, 1'b1);
    sel2 = has_fn(st_r.di_func, di_s, `RTS_FN_SEL2, 1'b1);
    fs_trig = has_fn(st_r.di_func, di_s, `RTS_FN_FSTOP_NO, 1'b1) // RULE2
           || has_fn(st_r.di_func, ~di_s, `RTS_FN_FSTOP_NC, 1'b1); // RULE3
    // Fast-stop latch and restart interlock.
    case (st_r.fs_state)
      rts_pkg::RTS_FS_IDLE:
        if (fs_trig)
        begin
          st_nxt.fs_state = rts_pkg::RTS_FS_DECEL; // RULE4
          st_nxt.run_ok   = 1'b0;
          ev[`RTS_IRQ_FSTOP] = 1'b1;
        end
        else if (!st_r.run_ok && run_s && !run_d_r)
          st_nxt.run_ok = 1'b1;
      rts_pkg::RTS_FS_DECEL:
        if (decel_done)
        begin
          st_nxt.fs_state = rts_pkg::RTS_FS_WAIT; // RULE4
          ev[`RTS_IRQ_DONE] = 1'b1;
        end
      rts_pkg::RTS_FS_WAIT:
        if (!fs_trig && !run_s)
          st_nxt.fs_state = rts_pkg::RTS_FS_IDLE; // RULE4
      default: st_nxt.fs_state = rts_pkg::RTS_FS_IDLE;
    endcase
    st_nxt.fstop_act = (st_nxt.fs_state != rts_pkg::RTS_FS_IDLE);
    // Pair choice, combining inputs, motor and frequency threshold.
    auto_on = (st_r.sw_freq != 16'h0000); // RULE8
    above   = !auto_on || (out_freq >= st_r.sw_freq);
    if (motor2_sel)
      p = sel1 ? 2'd3 : (above ? 2'd2 : 2'd3); // RULE10
    else if (sel1 || sel2)
      p = {sel2, sel1} - 2'd1 + 2'd1 == 2'd0 ? 2'd0
          : (sel1 && sel2) ? 2'd3 : (sel2 ? 2'd2 : 2'd1); // RULE1
    else
      p = above ? 2'd0 : 2'd3; // RULE7
    st_nxt.pair = p; // RULE13
    // Times are passed in the selected unit; slope is fmax over time.
    st_nxt.acc_time = st_r.time_set[{p, 1'b0}]; // RULE9
    st_nxt.dec_time = st_nxt.fstop_act ? st_r.time_set[8] // RULE2
                    : st_r.time_set[{p, 1'b1}];
    // Sticky status: set beats a clear by read.
    if (rd && !st_r.pready && paddr == `RTS_OFF_IRQ_STAT)
      st_nxt.irq_stat = ev;
    else
      st_nxt.irq_stat = st_r.irq_stat | ev;
    st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r           <= '0;
      for (int i = 0; i < 9; i++)
        st_r.time_set[i] <= `RTS_RST_TIME; // RULE12
      st_r.unit_fine <= !`RTS_RST_UNIT; // RULE5
      st_r.sw_freq   <= `RTS_RST_SWFREQ;
      st_r.max_freq  <= `RTS_RST_MAXFREQ;
      st_r.di_func   <= `RTS_RST_DIFUNC;
      st_r.fs_state  <= rts_pkg::RTS_FS_IDLE;
      st_r.acc_time  <= `RTS_RST_TIME;
      st_r.dec_time  <= `RTS_RST_TIME;
    end
    else
      st_r <= st_nxt;
  end

  assign prdata               = st_r.prdata;
  assign pready               = st_r.pready;
  assign pslverr              = st_r.pslverr;
  assign acc_time             = st_r.acc_time;
  assign dec_time             = st_r.dec_time;
  assign ramp_pair            = st_r.pair;
  assign unit_fine            = st_r.unit_fine;
  assign fast_stop            = st_r.fstop_act;
  assign run_enable           = st_r.run_ok;
  assign input_conflict_error = st_r.conflict;
  assign irq                  = st_r.irq;
endmodule

// [design/rts_sync.sv]
`timescale 1ns/100ps
// ====================================================================
// Two-stage synchroniser for the terminal inputs and run command.
module rts_sync
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [4:0] d_in,
  output logic      [4:0] q_out
);
  logic [4:0] meta_r;
  logic [4:0] sync_r;

  // First stage feeds only the second stage.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_r <= 5'h00;
      sync_r <= 5'h00;
    end
    else
    begin
      meta_r <= d_in;
      sync_r <= meta_r;
    end
  end

  assign q_out = sync_r;
endmodule

// [test/rts_contacts.sv]
`timescale 1ns/100ps
// ===================================================================
// Terminal contact bank and run command source.
module rts_contacts
(
  input  wire logic       pclk,
  input  wire logic [3:0] set_di,
  input  wire logic       set_run,
  output logic      [3:0] di_pin,
  output logic            run_cmd
);
  // Contacts change just after the clock edge, as a switch bank would.
  always_ff @(posedge pclk)
  begin
    di_pin  <= set_di;
    run_cmd <= set_run;
  end
endmodule

// [test/rts_sva.sv]
`timescale 1ns/100ps
// ===================================================================
// Port checker for the selector.
module rts_sva
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic unit_fine,
  input wire logic fast_stop,
  input wire logic run_enable,
  input wire logic run_cmd,
  input wire logic decel_done,
  input wire logic input_conflict_error
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held for more than one cycle");
  access_answer_a: assert property (psel && penable && !pready |=> pready)
    else $error("access not answered in one cycle");
  ready_cause_a: assert property (pready |-> $past(psel && penable))
    else $error("pready without an access");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr outside pready");
  unit_by_write_a: assert property (
    $changed(unit_fine) |-> pready || $past(pready))
    else $error("unit changed without write");
  conflict_flag_a: assert property (
    $rose(input_conflict_error) |-> pslverr || $past(pslverr))
    else $error("conflict without refusal");
  stop_blocks_a: assert property (
    fast_stop && $past(fast_stop) |-> !run_enable)
    else $error("run allowed during fast stop");
  run_start_a: assert property (
    $rose(run_enable) |-> $past(run_cmd) && !$past(fast_stop))
    else $error("bad run start");
  stop_release_a: assert property (
    $fell(fast_stop) |-> $past(decel_done))
    else $error("fast stop left before deceleration end");
endmodule
bind rts_selector rts_sva i_sva (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .unit_fine(unit_fine), .fast_stop(fast_stop), .run_enable(run_enable),
  .run_cmd(run_cmd), .decel_done(decel_done),
  .input_conflict_error(input_conflict_error));

// [test/testbench.sv]
`timescale 1ns/100ps
`include "rts_defines.svh"
// ===================================================================
// Self-checking bench for the ramp time selector.
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, motor2, decel, rerr;
  logic        pready, pslverr, unit_fine, fast_stop, run_en, icerr, irq;
  logic        run_cmd, set_run;
  logic [3:0]  di_pin, set_di;
  logic [11:0] paddr;
  logic [15:0] freq, acc_time, dec_time;
  logic [1:0]  pair;
  logic [31:0] pwdata, prdata, rdat;
  integer      failures, checks;
  rts_contacts i_con (.pclk(pclk), .set_di(set_di), .set_run(set_run),
    .di_pin(di_pin), .run_cmd(run_cmd));
  rts_selector i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .di_pin(di_pin),
    .run_cmd(run_cmd), .motor2_sel(motor2), .out_freq(freq),
    .decel_done(decel), .acc_time(acc_time), .dec_time(dec_time),
    .ramp_pair(pair), .unit_fine(unit_fine), .fast_stop(fast_stop),
    .run_enable(run_en), .input_conflict_error(icerr), .irq(irq));
  // Clock of 8 ns.
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // Prints the counts and the verdict, then ends the run.
  task wrap_up;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Compares one result.
  task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer; read data and error taken at the pready edge.
  task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    integer n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20)
    begin
      failures++;
      wrap_up;
    end
  endtask
  task settle;
    repeat (6) @(posedge pclk);
  endtask
  // Sets contacts, motor and frequency, then checks the chosen pair.
  task pick(input logic m, input logic [3:0] d, input logic [15:0] f,
            input logic [1:0] e);
    motor2 <= m; set_di <= d; freq <= f;
    settle;
    cmp("pair", {30'h0, e}, {30'h0, pair});
  endtask
  // Register defaults and an unmapped address.
  task s_reset;
    apb(0, `RTS_OFF_FSTOP, 0); cmp("fstop", 32'h64, rdat);
    apb(0, `RTS_OFF_UNIT, 0); cmp("unit", 32'h1, rdat);
    apb(0, `RTS_OFF_SWFREQ, 0); cmp("swfreq", 32'h0, rdat);
    cmp("acc", 32'h64, {16'h0, acc_time});
    apb(0, `RTS_OFF_MAXFREQ, 0);
    cmp("maxfreq", {16'h0, `RTS_RST_MAXFREQ}, rdat);
    apb(0, `RTS_OFF_ACTIVE, 0);
    cmp("active", {`RTS_RST_TIME, `RTS_RST_TIME}, rdat);
    apb(0, 12'h100, 0); cmp("unmapped", 32'h1, {31'h0, rerr});
  endtask
  // Pair choice by the two inputs, then by frequency and motor.
  task s_pairs;
    int i;
    apb(1, `RTS_OFF_DIFUNC, 32'h17151A07);
    for (i = 0; i < 4; i++)
    begin
      apb(1, 12'(i * 8), 32'(11 + 10 * i));
      apb(1, 12'(i * 8 + 4), 32'(12 + 10 * i));
    end
    for (i = 0; i < 4; i++)
    begin
      pick(0, {2'b10, 2'(i)}, 0, 2'(i));
      cmp("acc", 32'(11 + 10 * i), {16'h0, acc_time});
      cmp("dec", 32'(12 + 10 * i), {16'h0, dec_time});
    end
    apb(1, `RTS_OFF_SWFREQ, 32'h01F4);
    pick(0, 4'h8, 16'h0258, 2'h0);
    pick(0, 4'h8, 16'h01F3, 2'h3);
    pick(0, 4'h8, 16'h01F4, 2'h0);
    pick(1, 4'h8, 16'h0258, 2'h2);
    pick(1, 4'h8, 16'h0064, 2'h3);
    pick(1, 4'h9, 16'h0258, 2'h3);
    pick(0, 4'h9, 16'h0064, 2'h1);
    apb(1, `RTS_OFF_SWFREQ, 0);
    pick(0, 4'h8, 16'h0000, 2'h0);
  endtask
  // Ends a fast stop with decel done, then restarts the run command.
  task restart;
    decel <= 1'b1;
    settle;
    cmp("run held", 32'h0, {31'h0, run_en});
    set_run <= 1'b0;
    settle;
    set_run <= 1'b1;
    settle;
    cmp("stop", 32'h0, {31'h0, fast_stop});
    cmp("run", 32'h1, {31'h0, run_en});
    decel <= 1'b0;
  endtask
  // Fast stop by closing and by opening inputs, with its interrupt.
  task s_fstop;
    apb(1, `RTS_OFF_FSTOP, 32'h4D);
    set_run <= 1'b1;
    settle;
    cmp("run", 32'h1, {31'h0, run_en});
    set_di <= 4'hC;
    repeat (2) @(posedge pclk);
    set_di <= 4'h8;
    settle;
    cmp("stop", 32'h1, {31'h0, fast_stop});
    cmp("dec", 32'h4D, {16'h0, dec_time});
    cmp("run", 32'h0, {31'h0, run_en});
    apb(1, `RTS_OFF_IRQ_MASK, 0);
    settle;
    cmp("irq masked", 32'h0, {31'h0, irq});
    apb(1, `RTS_OFF_IRQ_MASK, 32'hF);
    settle;
    cmp("irq mask", 32'h1, {31'h0, irq});
    apb(0, `RTS_OFF_IRQ_STAT, 0); cmp("stat", 32'h1, rdat & 32'h1);
    apb(0, `RTS_OFF_IRQ_STAT, 0); cmp("stat", 32'h0, rdat);
    settle;
    cmp("irq", 32'h0, {31'h0, irq});
    restart;
    set_di <= 4'h0;
    settle;
    cmp("stop open", 32'h1, {31'h0, fast_stop});
    set_di <= 4'h8;
    restart;
  endtask
  // Fine unit refused at 600.1 s, accepted at 600.0 s.
  task unit_try(input logic [31:0] t, input logic e);
    apb(1, `RTS_OFF_UNIT, 1);
    apb(1, `RTS_OFF_ACC2, t);
    apb(1, `RTS_OFF_UNIT, 0);
    settle;
    cmp("unit err", {31'h0, e}, {31'h0, rerr});
    cmp("fine", {31'h0, !e}, {31'h0, unit_fine});
  endtask
  // Second select with motor switch is refused.
  task s_conflict;
    apb(1, `RTS_OFF_DIFUNC, 32'h00161A07);
    cmp("map err", 32'h1, {31'h0, rerr});
    settle;
    cmp("conflict", 32'h1, {31'h0, icerr});
    apb(0, `RTS_OFF_DIFUNC, 0); cmp("map", 32'h17151A07, rdat);
    apb(0, `RTS_OFF_STATUS, 0);
    cmp("status", 32'h34, rdat);
    apb(0, `RTS_OFF_IRQ_STAT, 0);
    cmp("irq events", 32'hF, rdat);
  endtask
  // Main sequence.
  initial
  begin
    failures = 0; checks = 0; presetn = 1'b0; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0; set_di = 4'h8;
    set_run = 1'b0; motor2 = 1'b0; freq = 16'h0000; decel = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    s_reset;
    s_pairs;
    s_fstop;
    unit_try(32'h1771, 1'b1);
    unit_try(32'h1770, 1'b0);
    s_conflict;
    wrap_up;
  end
endmodule
